// ==== common/mfw_pkg.sv ====
// Purpose: Shared constants and types for the management, flow, tag, wake and checksum register bank
// Assumes: One host clock domain, 32-bit register data
// Notes: Offsets are byte addresses on the plain register port
package mfw_pkg;

    // Register byte offsets
    localparam logic [7:0] MFW_OFS_MGMT_ACCESS = 8'h94;
    localparam logic [7:0] MFW_OFS_MGMT_DATA = 8'h98;
    localparam logic [7:0] MFW_OFS_FLOW = 8'h9c;
    localparam logic [7:0] MFW_OFS_TAG_ONE = 8'ha0;
    localparam logic [7:0] MFW_OFS_TAG_TWO = 8'ha4;
    localparam logic [7:0] MFW_OFS_WAKE_FILTER = 8'ha8;
    localparam logic [7:0] MFW_OFS_WAKE_CSR = 8'hac;
    localparam logic [7:0] MFW_OFS_CSUM = 8'hb0;

    // Management access fields
    localparam int MFW_MA_BUSY = 0;
    localparam int MFW_MA_WRITE = 1;
    localparam int MFW_MA_INDEX_LO = 6;
    localparam int MFW_MA_ADDR_LO = 11;
    // Flow control fields
    localparam int MFW_FL_BUSY = 0;
    localparam int MFW_FL_ENABLE = 1;
    localparam int MFW_FL_PASS = 2;
    localparam int MFW_FL_TIME_LO = 16;
    // Wake control fields
    localparam int MFW_WK_MAGIC_EN = 1;
    localparam int MFW_WK_FRAME_EN = 2;
    localparam int MFW_WK_MAGIC_RX = 5;
    localparam int MFW_WK_FRAME_RX = 6;
    localparam int MFW_WK_UNICAST_EN = 9;
    // Checksum control fields
    localparam int MFW_CS_RX_EN = 0;
    localparam int MFW_CS_RX_MODE = 1;
    localparam int MFW_CS_TX_EN = 16;

    // Reset values
    localparam logic [15:0] MFW_RST_TAG = 16'hffff;
    localparam logic [15:0] MFW_RST_MGMT_DATA = 16'h0000;
    localparam logic [31:0] MFW_RST_WAKE_WORD = 32'h0000_0000;

    // Frame lengths and timing
    localparam logic [10:0] MFW_LEN_PLAIN = 11'd1518;
    localparam logic [10:0] MFW_LEN_TAGGED = 11'd1522;
    localparam int MFW_SLOT_BIT_TIMES = 512;
    localparam int MFW_BITS_PER_CYCLE = 8;
    localparam int MFW_SLOT_CYCLES = MFW_SLOT_BIT_TIMES / MFW_BITS_PER_CYCLE;
    localparam int MFW_WAKE_WORDS = 8;

    typedef struct packed {
        logic [4:0] phy_addr;
        logic [4:0] index;
        logic write;
        logic [15:0] wdata;
    } mfw_mgmt_req_t;

    typedef enum logic [1:0] {
        MFW_MG_IDLE = 2'b00,
        MFW_MG_REQ = 2'b01,
        MFW_MG_WAIT = 2'b10
    } mfw_mgmt_state_t;

endpackage : mfw_pkg

// ==== design/mfw_regs.sv ====
// Purpose: Register bank for PHY management access, pause flow control, tag match, wake filter and checksum control
// Assumes: Plain register port with one-cycle strobes; all event inputs are on clk
// Notes: PHY registers are only reachable through the access/data pair
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

// Operation
// R1 - Software always writes PHY address one into the access register.
// R2 - The index field selects which PHY register the cycle touches.
// R3 - Write-select one writes data to the PHY; zero reads into data.
// R4 - Software sets busy to start; hardware clears it when done.
// R5 - Software waits for busy zero before writing access or data.
// R6 - Data stays fixed during a write; invalid during a read until done.
// R7 - Data register low sixteen bits hold read result or write value.
// R8 - PHY registers reach the host only through the access/data pair.
// R9 - Flow write with busy one sends a pause frame with pause time.
// R10 - Flow busy stays set while sending, clears when sending completes.
// R11 - Enabled full duplex: valid pause holds transmitter for time times slot.
// R12 - Pass-control set marks packet-filter flag on valid pause frames.
// R13 - All frames pass on; active filtering modes override pass-control.
// R14 - Two tag ids compared with bytes 13-14; match allows 1522 bytes.
// R15 - First tag id is the receive checksum tag protocol value.
// R16 - Wake filter pointer starts at zero, steps per access, wraps after eight.
// R17 - Software accesses the wake filter in bursts of eight words.
// R18 - Wake frame flag bit 6, magic flag bit 5; software write clears.
// R19 - Bit 2 frame wake, bit 1 magic wake, bit 9 unicast wake.
// R20 - Bit 16 enables transmit checksum engine; change only with tx off.
// R21 - Receive mode bit picks start at byte 14 or layer three header.
// R22 - Never enable receive checksum together with automatic pad stripping.
// R23 - Management reaches PHY indices 0-6, 17, 18, 27, 29, 30, 31.
// R24 - Reserved bits read zero and ignore writes.
module mfw_regs
    import mfw_pkg::*;
#(
    parameter int SLOT_CYCLES = MFW_SLOT_CYCLES,
    parameter int WAKE_WORDS = MFW_WAKE_WORDS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Internal PHY management port
    output mfw_mgmt_req_t mgmt_req,
    output logic mgmt_strobe,
    input wire logic mgmt_done,
    input wire logic [15:0] mgmt_rdata,
    // Pause transmit
    output logic pause_send_req,
    output logic [15:0] pause_time_value,
    input wire logic pause_send_done,
    // Pause receive and filtering
    input wire logic full_duplex,
    input wire logic promisc_mode,
    input wire logic rx_pause_valid,
    input wire logic [15:0] rx_pause_time,
    output logic rx_filter_flag,
    output logic tx_hold_off,
    // Tag match
    input wire logic rx_tag_valid,
    input wire logic [15:0] rx_tag_bytes,
    output logic rx_tagged,
    output logic [10:0] rx_max_len,
    output logic [15:0] rx_tag_protocol,
    // Wakeup
    input wire logic wake_frame_event,
    input wire logic magic_event,
    output logic [32*WAKE_WORDS-1:0] wake_filter_data,
    output logic wake_frame_enable,
    output logic magic_wake_enable,
    output logic unicast_wake_enable,
    // Checksum engines
    output logic tx_checksum_enable,
    output logic rx_checksum_enable,
    output logic rx_checksum_start_mode
);

    localparam int PTR_W = $clog2(WAKE_WORDS);
    function automatic logic phy_index_known(input logic [4:0] idx);
        phy_index_known = (idx <= 5'h06) || (idx == 5'h11) || (idx == 5'h12) || (idx == 5'h1b)
            || (idx >= 5'h1d);
    endfunction : phy_index_known
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit
    mfw_mgmt_state_t mg_state_reg;
    mfw_mgmt_req_t mgmt_req_reg;
    logic mgmt_strobe_reg;
    logic mgmt_busy_reg;
    logic [15:0] mgmt_data_reg;
    logic [15:0] pause_time_reg;
    logic pass_control_reg;
    logic flow_ctl_enable_reg;
    logic pause_busy_reg;
    logic pause_send_req_reg;
    logic [31:0] hold_cnt_reg;
    logic tx_hold_reg;
    logic rx_filter_reg;
    logic [15:0] tag_id_one_reg;
    logic [15:0] tag_id_two_reg;
    logic rx_tagged_reg;
    logic [10:0] rx_max_len_reg;
    logic [31:0] wake_mem [WAKE_WORDS];
    logic [PTR_W-1:0] wake_ptr_reg;
    logic wake_frame_rx_reg;
    logic magic_rx_reg;
    logic wake_frame_en_reg;
    logic magic_en_reg;
    logic unicast_en_reg;
    logic tx_csum_reg;
    logic rx_csum_reg;
    logic rx_mode_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    wire wr_access = reg_wr && hit(reg_addr, MFW_OFS_MGMT_ACCESS);
    wire wr_data = reg_wr && hit(reg_addr, MFW_OFS_MGMT_DATA);
    wire wr_flow = reg_wr && hit(reg_addr, MFW_OFS_FLOW);
    wire wr_csr = reg_wr && hit(reg_addr, MFW_OFS_WAKE_CSR);
    wire wake_acc = (reg_wr || reg_rd) && hit(reg_addr, MFW_OFS_WAKE_FILTER);
    wire mgmt_start = wr_access && !mgmt_busy_reg && reg_wdata[MFW_MA_BUSY];
    wire pause_start = wr_flow && !pause_busy_reg && reg_wdata[MFW_FL_BUSY];
    // Management cycle engine
    always_ff @(posedge clk) begin
        if (srst) begin
            mg_state_reg <= MFW_MG_IDLE;
            mgmt_req_reg <= '0;
            mgmt_strobe_reg <= 1'b0;
            mgmt_busy_reg <= 1'b0;
        end else begin
            mgmt_strobe_reg <= 1'b0;
            case (mg_state_reg)
                MFW_MG_IDLE: begin
                    if (mgmt_start) begin
                        mgmt_busy_reg <= 1'b1; // R4
                        mgmt_req_reg.phy_addr <= reg_wdata[MFW_MA_ADDR_LO +: 5];
                        mgmt_req_reg.index <= reg_wdata[MFW_MA_INDEX_LO +: 5]; // R2
                        mgmt_req_reg.write <= reg_wdata[MFW_MA_WRITE]; // R3
                        mgmt_req_reg.wdata <= mgmt_data_reg;
                        mg_state_reg <= MFW_MG_REQ;
                    end
                end
                MFW_MG_REQ: begin
                    if (phy_index_known(mgmt_req_reg.index)) begin
                        mgmt_strobe_reg <= 1'b1; // R23
                        mg_state_reg <= MFW_MG_WAIT;
                    end else begin
                        mgmt_busy_reg <= 1'b0;
                        mg_state_reg <= MFW_MG_IDLE;
                    end
                end
                MFW_MG_WAIT: begin
                    if (mgmt_done) begin
                        mgmt_busy_reg <= 1'b0; // R4
                        mg_state_reg <= MFW_MG_IDLE;
                    end
                end
                default: begin
                    mg_state_reg <= MFW_MG_IDLE;
                end
            endcase
        end
    end
    // Management data: host value or PHY read result
    always_ff @(posedge clk) begin
        if (srst) begin
            mgmt_data_reg <= MFW_RST_MGMT_DATA;
        end else if (mg_state_reg == MFW_MG_WAIT && mgmt_done && !mgmt_req_reg.write) begin
            mgmt_data_reg <= mgmt_rdata; // R3 R7
        end else if (mg_state_reg == MFW_MG_REQ && !mgmt_req_reg.write
                     && !phy_index_known(mgmt_req_reg.index)) begin
            mgmt_data_reg <= 16'h0000;
        end else if (wr_data && !mgmt_busy_reg) begin
            mgmt_data_reg <= reg_wdata[15:0]; // R6 R7
        end
    end
    // Flow control register and pause send
    always_ff @(posedge clk) begin
        if (srst) begin
            pause_time_reg <= 16'h0000;
            pass_control_reg <= 1'b0;
            flow_ctl_enable_reg <= 1'b0;
            pause_busy_reg <= 1'b0;
            pause_send_req_reg <= 1'b0;
        end else begin
            pause_send_req_reg <= pause_start; // R9
            if (wr_flow && !pause_busy_reg) begin
                pause_time_reg <= reg_wdata[MFW_FL_TIME_LO +: 16];
                pass_control_reg <= reg_wdata[MFW_FL_PASS];
                flow_ctl_enable_reg <= reg_wdata[MFW_FL_ENABLE];
            end
            if (pause_start) begin
                pause_busy_reg <= 1'b1; // R10
            end else if (pause_send_done) begin
                pause_busy_reg <= 1'b0; // R10
            end
        end
    end

    // Pause receive: hold-off timer and filter flag
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_cnt_reg <= '0;
            tx_hold_reg <= 1'b0;
            rx_filter_reg <= 1'b0;
        end else begin
            if (rx_pause_valid && flow_ctl_enable_reg && full_duplex) begin
                hold_cnt_reg <= 32'(rx_pause_time * SLOT_CYCLES); // R11
                tx_hold_reg <= (rx_pause_time != 16'h0000);
            end else if (hold_cnt_reg != '0) begin
                hold_cnt_reg <= hold_cnt_reg - 32'd1;
                tx_hold_reg <= (hold_cnt_reg != 32'd1);
            end else begin
                tx_hold_reg <= 1'b0;
            end
            rx_filter_reg <= rx_pause_valid && pass_control_reg && !promisc_mode; // R12 R13
        end
    end

    // Tag identifiers and match
    always_ff @(posedge clk) begin
        if (srst) begin
            tag_id_one_reg <= MFW_RST_TAG;
            tag_id_two_reg <= MFW_RST_TAG;
            rx_tagged_reg <= 1'b0;
            rx_max_len_reg <= MFW_LEN_PLAIN;
        end else begin
            if (reg_wr && hit(reg_addr, MFW_OFS_TAG_ONE)) begin
                tag_id_one_reg <= reg_wdata[15:0]; // R15
            end
            if (reg_wr && hit(reg_addr, MFW_OFS_TAG_TWO)) begin
                tag_id_two_reg <= reg_wdata[15:0];
            end
            if (rx_tag_valid) begin
                rx_tagged_reg <= (rx_tag_bytes == tag_id_one_reg) || (rx_tag_bytes == tag_id_two_reg); // R14
                rx_max_len_reg <= ((rx_tag_bytes == tag_id_one_reg) || (rx_tag_bytes == tag_id_two_reg))
                    ? MFW_LEN_TAGGED : MFW_LEN_PLAIN; // R14
            end
        end
    end

    // Wake filter store with wrapping pointer
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_ptr_reg <= '0;
            for (int i = 0; i < WAKE_WORDS; i++) begin
                wake_mem[i] <= MFW_RST_WAKE_WORD;
            end
        end else if (wake_acc) begin
            if (reg_wr) begin
                wake_mem[wake_ptr_reg] <= reg_wdata;
            end
            wake_ptr_reg <= (wake_ptr_reg == PTR_W'(WAKE_WORDS - 1)) ? '0 : wake_ptr_reg + 1'b1; // R16
        end
    end

    // Wake control and status
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_frame_rx_reg <= 1'b0;
            magic_rx_reg <= 1'b0;
            wake_frame_en_reg <= 1'b0;
            magic_en_reg <= 1'b0;
            unicast_en_reg <= 1'b0;
        end else begin
            if (wake_frame_event) begin
                wake_frame_rx_reg <= 1'b1; // R18
            end else if (wr_csr && reg_wdata[MFW_WK_FRAME_RX]) begin
                wake_frame_rx_reg <= 1'b0; // R18
            end
            if (magic_event) begin
                magic_rx_reg <= 1'b1; // R18
            end else if (wr_csr && reg_wdata[MFW_WK_MAGIC_RX]) begin
                magic_rx_reg <= 1'b0; // R18
            end
            if (wr_csr) begin
                wake_frame_en_reg <= reg_wdata[MFW_WK_FRAME_EN]; // R19
                magic_en_reg <= reg_wdata[MFW_WK_MAGIC_EN]; // R19
                unicast_en_reg <= reg_wdata[MFW_WK_UNICAST_EN]; // R19
            end
        end
    end

    // Checksum engine control
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_csum_reg <= 1'b0;
            rx_csum_reg <= 1'b0;
            rx_mode_reg <= 1'b0;
        end else if (reg_wr && hit(reg_addr, MFW_OFS_CSUM)) begin
            tx_csum_reg <= reg_wdata[MFW_CS_TX_EN]; // R20
            rx_csum_reg <= reg_wdata[MFW_CS_RX_EN];
            rx_mode_reg <= reg_wdata[MFW_CS_RX_MODE]; // R21
        end
    end

    // Read mux; PHY registers have no host address
    always_comb begin
        rdata_next = 32'h0000_0000; // R8 R24
        if (hit(reg_addr, MFW_OFS_MGMT_ACCESS)) begin
            rdata_next[MFW_MA_ADDR_LO +: 5] = mgmt_req_reg.phy_addr;
            rdata_next[MFW_MA_INDEX_LO +: 5] = mgmt_req_reg.index;
            rdata_next[MFW_MA_WRITE] = mgmt_req_reg.write;
            rdata_next[MFW_MA_BUSY] = mgmt_busy_reg;
        end else if (hit(reg_addr, MFW_OFS_MGMT_DATA)) begin
            rdata_next[15:0] = mgmt_data_reg;
        end else if (hit(reg_addr, MFW_OFS_FLOW)) begin
            rdata_next[MFW_FL_TIME_LO +: 16] = pause_time_reg;
            rdata_next[MFW_FL_PASS] = pass_control_reg;
            rdata_next[MFW_FL_ENABLE] = flow_ctl_enable_reg;
            rdata_next[MFW_FL_BUSY] = pause_busy_reg;
        end else if (hit(reg_addr, MFW_OFS_TAG_ONE)) begin
            rdata_next[15:0] = tag_id_one_reg;
        end else if (hit(reg_addr, MFW_OFS_TAG_TWO)) begin
            rdata_next[15:0] = tag_id_two_reg;
        end else if (hit(reg_addr, MFW_OFS_WAKE_FILTER)) begin
            rdata_next = wake_mem[wake_ptr_reg];
        end else if (hit(reg_addr, MFW_OFS_WAKE_CSR)) begin
            rdata_next[MFW_WK_UNICAST_EN] = unicast_en_reg;
            rdata_next[MFW_WK_FRAME_RX] = wake_frame_rx_reg;
            rdata_next[MFW_WK_MAGIC_RX] = magic_rx_reg;
            rdata_next[MFW_WK_FRAME_EN] = wake_frame_en_reg;
            rdata_next[MFW_WK_MAGIC_EN] = magic_en_reg;
        end else if (hit(reg_addr, MFW_OFS_CSUM)) begin
            rdata_next[MFW_CS_TX_EN] = tx_csum_reg;
            rdata_next[MFW_CS_RX_MODE] = rx_mode_reg;
            rdata_next[MFW_CS_RX_EN] = rx_csum_reg;
        end
    end

    always_ff @(posedge clk) begin
        rdata_reg <= (reg_rd && !srst) ? rdata_next : 32'h0000_0000;
    end

    // Outputs
    assign reg_rdata = rdata_reg;
    assign mgmt_req = mgmt_req_reg;
    assign mgmt_strobe = mgmt_strobe_reg;
    assign pause_send_req = pause_send_req_reg;
    assign pause_time_value = pause_time_reg; // R9
    assign rx_filter_flag = rx_filter_reg;
    assign tx_hold_off = tx_hold_reg;
    assign rx_tagged = rx_tagged_reg;
    assign rx_max_len = rx_max_len_reg;
    assign rx_tag_protocol = tag_id_one_reg; // R15
    assign wake_frame_enable = wake_frame_en_reg;
    assign magic_wake_enable = magic_en_reg;
    assign unicast_wake_enable = unicast_en_reg;
    assign tx_checksum_enable = tx_csum_reg;
    assign rx_checksum_enable = rx_csum_reg;
    assign rx_checksum_start_mode = rx_mode_reg;
    for (genvar g = 0; g < WAKE_WORDS; g++) begin : g_wake
        assign wake_filter_data[32*g +: 32] = wake_mem[g];
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_MGMT_LAUNCH: assert property ( // R4
        mgmt_start |=> mgmt_busy_reg ##1 (mgmt_strobe_reg || !mgmt_busy_reg))
        else $error("management start did not launch");
    AST_MGMT_INDEX: assert property ( // R2
        mgmt_start |-> ##2 (mgmt_strobe_reg -> mgmt_req_reg.index == $past(reg_wdata[10:6], 2)))
        else $error("management index not taken from access write");
    AST_MGMT_DONE: assert property ( // R4
        (mg_state_reg == MFW_MG_WAIT && mgmt_done) |=> !mgmt_busy_reg)
        else $error("busy not cleared after done");
    AST_MGMT_READ: assert property ( // R3
        (mg_state_reg == MFW_MG_WAIT && mgmt_done && !mgmt_req_reg.write) |=> mgmt_data_reg == $past(mgmt_rdata))
        else $error("read result not captured");
    AST_DATA_HOLD: assert property ( // R6
        (mgmt_busy_reg && mgmt_req_reg.write && !mgmt_done) |=> $stable(mgmt_data_reg))
        else $error("data changed during write");
    AST_PAUSE_SEND: assert property ( // R9
        pause_start |=> pause_send_req_reg && pause_busy_reg && pause_time_value == $past(reg_wdata[31:16]))
        else $error("pause send not issued");
    AST_PAUSE_CLEAR: assert property ( // R10
        (pause_busy_reg && pause_send_done && !pause_start) |=> !pause_busy_reg)
        else $error("pause busy not cleared");
    AST_HOLD_LOAD: assert property ( // R11
        (rx_pause_valid && flow_ctl_enable_reg && full_duplex && rx_pause_time == 16'h0001)
        |=> tx_hold_reg [*2])
        else $error("pause hold-off not applied");
    AST_FILTER_FLAG: assert property ( // R12
        (rx_pause_valid && !promisc_mode) |=> rx_filter_reg == $past(pass_control_reg))
        else $error("filter flag wrong");
    AST_TAG_LEN: assert property ( // R14
        rx_tag_valid |=> rx_max_len_reg == ((($past(rx_tag_bytes) == $past(tag_id_one_reg))
        || ($past(rx_tag_bytes) == $past(tag_id_two_reg))) ? MFW_LEN_TAGGED : MFW_LEN_PLAIN))
        else $error("tag length mismatch");
    AST_WAKE_WRAP: assert property ( // R16
        (wake_acc && wake_ptr_reg == PTR_W'(WAKE_WORDS - 1)) |=> wake_ptr_reg == '0)
        else $error("wake pointer did not wrap");
    AST_WAKE_SET: assert property ( // R18
        (wake_frame_event || magic_event) |=> (wake_frame_rx_reg || !$past(wake_frame_event))
        && (magic_rx_reg || !$past(magic_event)))
        else $error("wake flag lost");
endmodule : mfw_regs

// ==== tb/mfw_phy_model.sv ====
// Purpose: Far-side model of the internal PHY and the pause frame sender
// Assumes: Each pause request, and each management request to PHY address one, is answered lat+1 cycles after it is seen
// Notes: Read data toggles every cycle outside a reply
`timescale 1ns/1ps
module mfw_phy_model
    import mfw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Management side
    input wire mfw_mgmt_req_t mgmt_req,
    input wire logic mgmt_strobe,
    output logic mgmt_done,
    output logic [15:0] mgmt_rdata,
    // Pause side
    input wire logic pause_send_req,
    output logic pause_send_done,
    input wire logic [3:0] lat
);
    logic [15:0] phy_reg [32];
    int mcnt;
    int pcnt;
    always_ff @(posedge clk) begin
        mgmt_done <= 1'b0;
        pause_send_done <= 1'b0;
        mgmt_rdata <= ~mgmt_rdata;
        mcnt <= (mcnt > 0) ? mcnt - 1 : 0;
        pcnt <= (pcnt > 0) ? pcnt - 1 : 0;
        if (mgmt_strobe && mgmt_req.phy_addr == 5'h01) mcnt <= lat + 1;
        if (pause_send_req) pcnt <= lat + 1;
        if (pcnt == 1) pause_send_done <= 1'b1;
        if (mcnt == 1) begin
            mgmt_done <= 1'b1;
            if (mgmt_req.write) phy_reg[mgmt_req.index] <= mgmt_req.wdata;
            else mgmt_rdata <= phy_reg[mgmt_req.index];
        end
        if (srst) begin
            mcnt <= 0;
            pcnt <= 0;
            mgmt_rdata <= 16'h5a5a;
        end
    end
endmodule : mfw_phy_model

// ==== tb/mfw_regs_tb_top.sv ====
// Purpose: Self-checking bench for the register bank
// Assumes: Slot count of 2 cycles, PHY model latency 5
// Notes: Expected values come from a mirror kept in the bench
`timescale 1ns/1ps
module mfw_regs_tb_top;
    import mfw_pkg::*;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, full_duplex = 0, promisc_mode = 0;
    logic rx_pause_valid = 0, rx_tag_valid = 0, wake_frame_event = 0, magic_event = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, seed = 32'hc7e4, v, d;
    logic [15:0] rx_pause_time = 0, rx_tag_bytes = 0, mgmt_rdata, pause_time_value, rx_tag_protocol;
    logic [3:0] lat = 4'h5;
    mfw_mgmt_req_t mgmt_req;
    logic mgmt_strobe, mgmt_done, pause_send_req, pause_send_done, rx_filter_flag, tx_hold_off, rx_tagged;
    logic wake_frame_enable, magic_wake_enable, unicast_wake_enable;
    logic tx_checksum_enable, rx_checksum_enable, rx_checksum_start_mode;
    logic [10:0] rx_max_len;
    logic [255:0] wake_filter_data;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    int known[13] = '{0, 1, 2, 3, 4, 5, 6, 17, 18, 27, 29, 30, 31};
    logic [31:0] q[$];
    mfw_regs #(.SLOT_CYCLES(2), .WAKE_WORDS(8)) dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .mgmt_req, .mgmt_strobe, .mgmt_done, .mgmt_rdata, .pause_send_req, .pause_time_value,
        .pause_send_done, .full_duplex, .promisc_mode, .rx_pause_valid, .rx_pause_time, .rx_filter_flag,
        .tx_hold_off, .rx_tag_valid, .rx_tag_bytes, .rx_tagged, .rx_max_len, .rx_tag_protocol,
        .wake_frame_event, .magic_event, .wake_filter_data, .wake_frame_enable, .magic_wake_enable,
        .unicast_wake_enable, .tx_checksum_enable, .rx_checksum_enable, .rx_checksum_start_mode);
    mfw_phy_model phy (.clk, .srst, .mgmt_req, .mgmt_strobe, .mgmt_done, .mgmt_rdata, .pause_send_req,
        .pause_send_done, .lat);
    always #4 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        chk(d, e);
    endtask : rc
    // Poll a busy bit, optionally checking it was seen set first
    task automatic pl(input logic [7:0] a, input logic [31:0] e, input logic b);
        rd(a, d);
        if (b) chk(d[0], 1);
        repeat (40) if (d[0] !== 1'b0) rd(a, d);
        chk(d, e);
    endtask : pl
    task automatic mg(input int idx, input logic w, input logic [15:0] dat, input logic kn);
        logic [31:0] acc;
        acc = 32'hffff_083d | (32'(idx) << 6) | {30'h0, w, 1'b0};
        wr(MFW_OFS_MGMT_DATA, {16'hffff, w ? dat : ~dat});
        wr(MFW_OFS_MGMT_ACCESS, acc);
        if (kn) wr(MFW_OFS_MGMT_DATA, 32'h0000_1234);
        pl(MFW_OFS_MGMT_ACCESS, acc & 32'h0000_ffc2, kn);
        rc(MFW_OFS_MGMT_DATA, kn ? {16'h0, dat} : 32'h0);
    endtask : mg
    task automatic rxp(input logic [15:0] t, input logic pm, input logic fd, input int eh);
        int c;
        c = 0;
        @(posedge clk);
        rx_pause_valid <= 1'b1;
        rx_pause_time <= t;
        promisc_mode <= pm;
        full_duplex <= fd;
        @(posedge clk);
        rx_pause_valid <= 1'b0;
        #1 chk(rx_filter_flag, !pm);
        repeat (30) begin
            c += int'(tx_hold_off === 1'b1);
            @(posedge clk);
            #1;
        end
        chk(c, eh);
    endtask : rxp
    task automatic tg(input logic [15:0] b, input logic m);
        @(posedge clk);
        rx_tag_valid <= 1'b1;
        rx_tag_bytes <= b;
        @(posedge clk);
        rx_tag_valid <= 1'b0;
        #1 chk({rx_tagged, rx_max_len}, {m, m ? MFW_LEN_TAGGED : MFW_LEN_PLAIN});
    endtask : tg
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rc(MFW_OFS_MGMT_ACCESS, 0);
        rc(MFW_OFS_TAG_TWO, 32'hffff);
        rc(MFW_OFS_WAKE_CSR, 0);
        rc(8'hb4, 0);
        foreach (known[i]) begin
            v = rnd();
            mg(known[i], 1'b1, v[15:0], 1'b1);
            mg(known[i], 1'b0, v[15:0], 1'b1);
        end
        mg(7, 1'b0, 16'h0, 1'b0);
        mg(20, 1'b0, 16'h0, 1'b0);
        v = rnd();
        wr(MFW_OFS_FLOW, {v[31:16], 16'hffff});
        pl(MFW_OFS_FLOW, {v[31:16], 16'h0006}, 1'b1);
        chk(pause_time_value, v[31:16]);
        rxp(16'h0003, 1'b0, 1'b1, 6);
        rxp(16'h0001, 1'b0, 1'b1, 2);
        rxp(16'h0002, 1'b1, 1'b0, 0);
        wr(MFW_OFS_TAG_ONE, {16'hffff, v[15:0]});
        wr(MFW_OFS_TAG_TWO, {16'hffff, ~v[15:0]});
        rc(MFW_OFS_TAG_ONE, {16'h0, v[15:0]});
        chk(rx_tag_protocol, v[15:0]);
        tg(v[15:0], 1'b1);
        tg(~v[15:0], 1'b1);
        tg(v[15:0] ^ 16'h0f00, 1'b0);
        for (int i = 0; i < 8; i++) begin
            q.push_back(rnd());
            wr(MFW_OFS_WAKE_FILTER, q[i]);
        end
        for (int i = 0; i < 8; i++) begin
            chk(wake_filter_data[32*i+:32], q[i]);
            rc(MFW_OFS_WAKE_FILTER, q[i]);
        end
        wr(MFW_OFS_WAKE_FILTER, 32'h0000_00a5);
        #1 chk(wake_filter_data[31:0], 32'h0000_00a5);
        wr(MFW_OFS_WAKE_CSR, 32'hffff_ffff);
        rc(MFW_OFS_WAKE_CSR, 32'h0000_0206);
        chk({unicast_wake_enable, wake_frame_enable, magic_wake_enable}, 3'b111);
        @(posedge clk);
        magic_event <= 1'b1;
        wake_frame_event <= 1'b1;
        @(posedge clk);
        magic_event <= 1'b0;
        wake_frame_event <= 1'b0;
        rc(MFW_OFS_WAKE_CSR, 32'h0000_0266);
        wr(MFW_OFS_WAKE_CSR, 32'h0000_0060);
        rc(MFW_OFS_WAKE_CSR, 0);
        repeat (4) begin
            v = rnd() | 32'hfffe_fffc;
            wr(MFW_OFS_CSUM, v);
            rc(MFW_OFS_CSUM, v & 32'h0001_0003);
            chk({tx_checksum_enable, rx_checksum_start_mode, rx_checksum_enable}, {v[16], v[1:0]});
        end
        report_and_stop();
    end
endmodule : mfw_regs_tb_top
